// ---- cmmc_top.sv ----
// CAN module control register, enable sequencing and mode management
`timescale 1ns/1ps
`default_nettype none
module cmmc_top (
    input  wire logic                           sys_clk,
    input  wire logic                           sys_rst,
    input  wire logic                           hsel,
    input  wire logic [31:0]                    haddr,
    input  wire logic [1:0]                     htrans,
    input  wire logic                           hwrite,
    input  wire logic [2:0]                     hsize,
    input  wire logic [31:0]                    hwdata,
    input  wire logic                           hready,
    output logic [31:0]                         hrdata,
    output logic                                hreadyout,
    output logic                                hresp,
    input  wire logic                           sys_idle,
    input  wire logic                           xact_active,
    input  wire logic                           tx_pending,
    input  wire logic                           rx_msg_valid,
    output logic                                tx_abort_req,
    output logic                                can_run,
    output logic [2:0]                          op_mode,
    output logic [cmmc_pkg::FILT_BITS-1:0]      filter_compare_mask,
    output logic [cmmc_pkg::TMR_W-1:0]          rx_stamp,
    output logic                                rx_stamp_valid
);
    //==========================================================================
    // Register state
    logic                           abort_all_pending_tx;
    logic [2:0]                     requested_op_mode;
    logic [2:0]                     current_op_mode;
    logic                           rx_timestamp_capture_enable;
    logic                           module_on;
    logic                           stop_in_idle;
    logic                           module_active_status;
    logic [4:0]                     filter_data_bit_count;
    cmmc_pkg::cmmc_state_t          state;
    cmmc_pkg::cmmc_state_t          next_state;
    logic [cmmc_pkg::TMR_W-1:0]     rx_timestamp_timer;
    logic                           timer_run;

    //==========================================================================
    // Bus slave
    logic       dp_wr;
    logic       dp_rd_ctrl;
    logic [7:0] dp_ofs;
    logic       addr_ok;
    logic       wr_ctrl;
    logic [7:0] a_ofs;

    assign a_ofs   = haddr[7:0] & cmmc_pkg::OFS_MASK;
    assign addr_ok = hsel && hready && (htrans == cmmc_pkg::HTRANS_NSEQ);
    assign wr_ctrl = dp_wr && (dp_ofs == cmmc_pkg::CTRL_OFS);

    // Writes commit in the data phase; narrow sizes are ignored
    always_ff @(posedge sys_clk or posedge sys_rst) begin
        if (sys_rst) begin
            dp_wr      <= 1'b0;
            dp_rd_ctrl <= 1'b0;
            dp_ofs     <= 8'h00;
        end else begin
            dp_wr      <= addr_ok && hwrite && (hsize == cmmc_pkg::HSIZE_WORD);
            dp_rd_ctrl <= addr_ok && !hwrite && (a_ofs == cmmc_pkg::CTRL_OFS);
            dp_ofs     <= a_ofs;
        end
    end

    // Zero-wait slave; unmapped offsets read zero
    always_ff @(posedge sys_clk or posedge sys_rst) begin
        if (sys_rst) begin
            hrdata    <= 32'h0000_0000;
            hreadyout <= 1'b1;
            hresp     <= 1'b0;
        end else begin
            hreadyout <= 1'b1;
            hresp     <= 1'b0;
            if (addr_ok && !hwrite) begin
                case (a_ofs)
                    // [R10] reserved read zero
                    cmmc_pkg::CTRL_OFS: hrdata <= ctrl_word();
                    cmmc_pkg::TMR_OFS:  hrdata <= {{(32 - cmmc_pkg::TMR_W){1'b0}}, rx_timestamp_timer};
                    default:            hrdata <= 32'h0000_0000;
                endcase
            end
        end
    end

    function automatic logic [31:0] ctrl_word();
        logic [31:0] w;
        w = 32'h0000_0000;
        w[cmmc_pkg::ABORT_BIT]              = abort_all_pending_tx;
        w[cmmc_pkg::REQ_LSB +: 3]           = requested_op_mode;
        w[cmmc_pkg::CUR_LSB +: 3]           = current_op_mode;
        w[cmmc_pkg::CAP_BIT]                = rx_timestamp_capture_enable;
        w[cmmc_pkg::ON_BIT]                 = module_on;
        w[cmmc_pkg::STOP_IN_IDLE_BIT]              = stop_in_idle;
        w[cmmc_pkg::BUSY_BIT]               = module_active_status;
        w[cmmc_pkg::CNT_LSB +: 5]           = filter_data_bit_count;
        return w & cmmc_pkg::CTRL_RMASK;
    endfunction

    //==========================================================================
    // Plain control fields
    // [R10] writes only to implemented bits
    always_ff @(posedge sys_clk or posedge sys_rst) begin
        if (sys_rst) begin
            requested_op_mode           <= cmmc_pkg::MODE_RESET;
            rx_timestamp_capture_enable <= 1'b0;
            module_on                   <= 1'b0;
            stop_in_idle                <= 1'b0;
            filter_data_bit_count       <= 5'h00;
        end else if (wr_ctrl) begin
            requested_op_mode           <= hwdata[cmmc_pkg::REQ_LSB +: 3];
            rx_timestamp_capture_enable <= hwdata[cmmc_pkg::CAP_BIT];
            module_on                   <= hwdata[cmmc_pkg::ON_BIT];
            stop_in_idle                <= hwdata[cmmc_pkg::STOP_IN_IDLE_BIT];
            filter_data_bit_count       <= hwdata[cmmc_pkg::CNT_LSB +: 5];
        end
    end

    //==========================================================================
    // Abort all pending transmissions
    logic abort_set;
    assign abort_set = wr_ctrl && hwdata[cmmc_pkg::ABORT_BIT];

    // Writing 0 has no effect; a new set beats the self-clear in the same cycle
    // [R1] abort and self-clear
    always_ff @(posedge sys_clk or posedge sys_rst) begin
        if (sys_rst) begin
            abort_all_pending_tx <= 1'b0;
            tx_abort_req         <= 1'b0;
        end else begin
            if (abort_set) begin
                abort_all_pending_tx <= 1'b1;
            end else if (abort_all_pending_tx && tx_abort_req && !tx_pending) begin
                abort_all_pending_tx <= 1'b0;
            end
            tx_abort_req <= abort_set || (abort_all_pending_tx && !(tx_abort_req && !tx_pending));
        end
    end

    //==========================================================================
    // Enable sequencing
    always_comb begin
        next_state = state;
        case (state)
            cmmc_pkg::CMMC_OFF: begin
                if (module_on) begin
                    next_state = cmmc_pkg::CMMC_RUN;
                end
            end
            cmmc_pkg::CMMC_RUN: begin
                if (!module_on) begin
                    next_state = cmmc_pkg::CMMC_DRAIN;
                end
            end
            cmmc_pkg::CMMC_DRAIN: begin
                if (module_on) begin
                    next_state = cmmc_pkg::CMMC_RUN;
                end else if (!xact_active) begin
                    // [R5] shut down after transaction
                    next_state = cmmc_pkg::CMMC_OFF;
                end
            end
            default: next_state = cmmc_pkg::CMMC_OFF;
        endcase
    end

    // [R6] busy until fully off
    always_ff @(posedge sys_clk or posedge sys_rst) begin
        if (sys_rst) begin
            state                <= cmmc_pkg::CMMC_OFF;
            module_active_status <= 1'b0;
        end else begin
            state                <= next_state;
            module_active_status <= (next_state != cmmc_pkg::CMMC_OFF);
        end
    end

    // A draining module keeps running so the open transaction can finish
    // [R7] halt while idle
    always_ff @(posedge sys_clk or posedge sys_rst) begin
        if (sys_rst) begin
            can_run <= 1'b0;
        end else begin
            can_run <= (next_state != cmmc_pkg::CMMC_OFF) && !(stop_in_idle && sys_idle);
        end
    end

    //==========================================================================
    // Mode management
    // Reserved requests are never acted on; the status keeps the last good mode
    // [R3] status resets to config
    // [R12] switch between transactions
    always_ff @(posedge sys_clk or posedge sys_rst) begin
        if (sys_rst) begin
            current_op_mode <= cmmc_pkg::MODE_RESET;
            op_mode         <= cmmc_pkg::MODE_RESET;
        end else begin
            // [R2] reserved codes ignored
            if (requested_op_mode != current_op_mode && !xact_active
                && cmmc_pkg::cmmc_mode_ok(requested_op_mode)) begin
                current_op_mode <= requested_op_mode;
            end
            op_mode <= current_op_mode;
        end
    end

    //==========================================================================
    // Time stamp and filter
    assign timer_run = rx_timestamp_capture_enable && can_run;

    cmmc_stamp_timer u_stamp (
        .sys_clk     (sys_clk),
        .sys_rst     (sys_rst),
        .run         (timer_run),
        .rx_valid    (rx_msg_valid),
        .timer       (rx_timestamp_timer),
        .stamp       (rx_stamp),
        .stamp_valid (rx_stamp_valid)
    );

    cmmc_filter_mask u_filter (
        .sys_clk      (sys_clk),
        .sys_rst      (sys_rst),
        .bit_count    (filter_data_bit_count),
        .compare_mask (filter_compare_mask)
    );

    //==========================================================================
    // Assertions
    property p_abort_clear;
        @(posedge sys_clk) disable iff (sys_rst)
        (tx_abort_req && !tx_pending && !abort_set) |=> !abort_all_pending_tx;
    endproperty
    a_abort_clear: assert property (p_abort_clear) else $error("abort bit not cleared"); // [R1]

    property p_abort_hold;
        @(posedge sys_clk) disable iff (sys_rst)
        (abort_all_pending_tx && tx_pending) |=> abort_all_pending_tx && tx_abort_req;
    endproperty
    a_abort_hold: assert property (p_abort_hold) else $error("abort dropped early"); // [R1]

    property p_mode_rsv;
        @(posedge sys_clk) disable iff (sys_rst)
        !cmmc_pkg::cmmc_mode_ok(requested_op_mode) |=> $stable(current_op_mode);
    endproperty
    a_mode_rsv: assert property (p_mode_rsv) else $error("reserved mode taken"); // [R2]

    property p_mode_valid;
        @(posedge sys_clk) disable iff (sys_rst)
        cmmc_pkg::cmmc_mode_ok(current_op_mode) ##1 cmmc_pkg::cmmc_mode_ok(op_mode);
    endproperty
    a_mode_valid: assert property (p_mode_valid) else $error("status shows reserved mode"); // [R3]

    property p_stamp_stop;
        @(posedge sys_clk) disable iff (sys_rst)
        !rx_timestamp_capture_enable |=> $stable(rx_timestamp_timer) && !rx_stamp_valid;
    endproperty
    a_stamp_stop: assert property (p_stamp_stop) else $error("timer ran while disabled"); // [R4]

    property p_drain;
        @(posedge sys_clk) disable iff (sys_rst)
        (!module_on && xact_active && state != cmmc_pkg::CMMC_OFF) |=> module_active_status;
    endproperty
    a_drain: assert property (p_drain) else $error("shut down mid transaction"); // [R5]

    property p_busy_fall;
        @(posedge sys_clk) disable iff (sys_rst)
        $fell(module_active_status) |-> $past(!module_on && !xact_active) && !can_run;
    endproperty
    a_busy_fall: assert property (p_busy_fall) else $error("busy fell while active"); // [R6]

    property p_idle_halt;
        @(posedge sys_clk) disable iff (sys_rst)
        (stop_in_idle && sys_idle) |=> !can_run;
    endproperty
    a_idle_halt: assert property (p_idle_halt) else $error("ran during idle"); // [R7]

    property p_filt_zero;
        @(posedge sys_clk) disable iff (sys_rst)
        (filter_data_bit_count == 5'h00) [*2] |-> filter_compare_mask == '0;
    endproperty
    a_filt_zero: assert property (p_filt_zero) else $error("mask not empty"); // [R8]

    property p_filt_step;
        @(posedge sys_clk) disable iff (sys_rst)
        (filter_data_bit_count == 5'h01) [*2] |-> filter_compare_mask == 18'h0_0001;
    endproperty
    a_filt_step: assert property (p_filt_step) else $error("first pair wrong"); // [R11]

    property p_rsv_zero;
        @(posedge sys_clk) disable iff (sys_rst)
        dp_rd_ctrl |-> (hrdata & ~cmmc_pkg::CTRL_RMASK) == 32'h0000_0000;
    endproperty
    a_rsv_zero: assert property (p_rsv_zero) else $error("reserved bits read set"); // [R10]

    property p_mode_wait;
        @(posedge sys_clk) disable iff (sys_rst)
        $changed(current_op_mode) |-> $past(!xact_active) && current_op_mode == $past(requested_op_mode);
    endproperty
    a_mode_wait: assert property (p_mode_wait) else $error("mode changed mid transaction"); // [R12]

    c_abort: cover property (@(posedge sys_clk) disable iff (sys_rst) $fell(abort_all_pending_tx));
    c_mode:  cover property (@(posedge sys_clk) disable iff (sys_rst) $changed(current_op_mode));
    c_off:   cover property (@(posedge sys_clk) disable iff (sys_rst) $fell(module_active_status));
    c_stamp: cover property (@(posedge sys_clk) disable iff (sys_rst) rx_stamp_valid);
endmodule // cmmc_top
`default_nettype wire

// ---- cmmc_pkg.sv ----
// Constants, types and helpers for the CAN module mode control block
//==============================================================================
// Operation
// [R1] Setting the abort bit tells every transmit buffer to abandon its frame; hardware clears the bit when done.
// [R2] The requested mode decodes 0 normal, 1 disable, 2 loopback, 3 listen only, 4 config, 7 listen all; 5 and 6 are reserved.
// [R3] The read-only mode status uses the same codes and resets to configuration (4).
// [R4] With capture enabled the timer is stored on each valid received frame; disabled, capture stops and the timer halts.
// [R5] Clearing the enable bit takes effect only after the current transaction ends; software polls the busy bit.
// [R6] The busy bit reads 1 while the module is active and 0 only once it is fully disabled.
// [R7] With stop-in-idle set the module halts while the system idles; clear, it keeps running.
// [R8] The five-bit filter count selects how many data bits are compared with extended identifier filter bits, 0 to 18.
// [R9] Software never programs filter counts 19 to 31.
// [R10] Bits 31-28, 19-16, 14, 12 and 10-5 of the control register read zero and ignore writes.
// [R11] Each filter count step adds one data bit paired with the next higher identifier filter bit.
// [R12] The mode status changes to a new request only once the transition has completed.
package cmmc_pkg;
    //==========================================================================
    // Register map
    localparam logic [7:0]  CTRL_OFS    = 8'h00;
    localparam logic [7:0]  TMR_OFS     = 8'h04;
    localparam logic [7:0]  OFS_MASK    = 8'hFC;
    //==========================================================================
    // Control register fields
    localparam int          ABORT_BIT   = 27;
    localparam int          REQ_LSB     = 24;
    localparam int          CUR_LSB     = 21;
    localparam int          CAP_BIT     = 20;
    localparam int          ON_BIT      = 15;
    localparam int          STOP_IN_IDLE_BIT   = 13;
    localparam int          BUSY_BIT    = 11;
    localparam int          CNT_LSB     = 0;
    localparam logic [31:0] CTRL_RMASK  = 32'h0FF0_A81F;
    //==========================================================================
    // Operating modes
    localparam logic [2:0]  MODE_NORMAL = 3'h0;
    localparam logic [2:0]  MODE_DIS    = 3'h1;
    localparam logic [2:0]  MODE_LOOP   = 3'h2;
    localparam logic [2:0]  MODE_LISTEN = 3'h3;
    localparam logic [2:0]  MODE_CONFIG = 3'h4;
    localparam logic [2:0]  MODE_RSV5   = 3'h5;
    localparam logic [2:0]  MODE_RSV6   = 3'h6;
    localparam logic [2:0]  MODE_ALL    = 3'h7;
    localparam logic [2:0]  MODE_RESET  = MODE_CONFIG;
    //==========================================================================
    // Filter and timer
    localparam int          FILT_BITS   = 18;
    localparam logic [4:0]  CNT_MAX     = 5'h12;
    localparam int          TMR_W       = 16;
    //==========================================================================
    // Bus codes
    localparam logic [1:0]  HTRANS_NSEQ = 2'h2;
    localparam logic [2:0]  HSIZE_WORD  = 3'h2;

    typedef enum logic [2:0] {
        CMMC_OFF   = 3'b001,
        CMMC_RUN   = 3'b010,
        CMMC_DRAIN = 3'b100
    } cmmc_state_t;

    function automatic logic cmmc_mode_ok(input logic [2:0] m);
        return (m != MODE_RSV5) && (m != MODE_RSV6);
    endfunction

    function automatic logic [FILT_BITS-1:0] cmmc_mask(input logic [4:0] n);
        logic [FILT_BITS-1:0] r;
        r = '0;
        for (int i = 0; i < FILT_BITS; i++) begin
            r[i] = (5'(i) < n);
        end
        return r;
    endfunction
endpackage

// ---- cmmc_stamp_timer.sv ----
// Receive time-stamp timer with capture on valid frames
`timescale 1ns/1ps
`default_nettype none
module cmmc_stamp_timer (
    input  wire logic                       sys_clk,
    input  wire logic                       sys_rst,
    input  wire logic                       run,
    input  wire logic                       rx_valid,
    output logic [cmmc_pkg::TMR_W-1:0]      timer,
    output logic [cmmc_pkg::TMR_W-1:0]      stamp,
    output logic                            stamp_valid
);
    // [R4] timer halts
    always_ff @(posedge sys_clk or posedge sys_rst) begin
        if (sys_rst) begin
            timer <= '0;
        end else if (run) begin
            timer <= timer + 1'b1;
        end
    end

    // [R4] capture on frame
    always_ff @(posedge sys_clk or posedge sys_rst) begin
        if (sys_rst) begin
            stamp       <= '0;
            stamp_valid <= 1'b0;
        end else begin
            stamp_valid <= run && rx_valid;
            if (run && rx_valid) begin
                stamp <= timer;
            end
        end
    end
endmodule // cmmc_stamp_timer
`default_nettype wire

// ---- cmmc_filter_mask.sv ----
// Data-bit compare mask for the extended identifier filter
`timescale 1ns/1ps
`default_nettype none
module cmmc_filter_mask (
    input  wire logic                           sys_clk,
    input  wire logic                           sys_rst,
    input  wire logic [4:0]                     bit_count,
    output logic [cmmc_pkg::FILT_BITS-1:0]      compare_mask
);
    // Bit i pairs data bit i (from data byte 0 bit 7 down) with identifier filter bit i.
    // Invalid counts saturate at the full width rather than wrapping.
    // [R8] count to mask
    always_ff @(posedge sys_clk or posedge sys_rst) begin
        if (sys_rst) begin
            compare_mask <= '0;
        end else if (bit_count > cmmc_pkg::CNT_MAX) begin
            compare_mask <= '1;
        end else begin
            // [R11] one bit per step
            compare_mask <= cmmc_pkg::cmmc_mask(bit_count);
        end
    end
endmodule // cmmc_filter_mask
`default_nettype wire

// ---- cmmc_can_node_model.sv ----
// Behavioural model of the CAN protocol side seen by the mode control block
`timescale 1ns/1ps
`default_nettype none
module cmmc_can_node_model (
    input  wire logic       sys_clk,
    input  wire logic       sys_rst,
    input  wire logic       can_run,
    input  wire logic       tx_abort_req,
    input  wire logic [7:0] xact_len,
    input  wire logic       start_xact,
    input  wire logic       load_tx,
    input  wire logic [3:0] abort_lat,
    input  wire logic       send_frame,
    output logic            xact_active,
    output logic            tx_pending,
    output logic            rx_msg_valid
);
    logic [7:0] xact_cnt;
    logic [3:0] abort_cnt;
    //==========================================================================
    // Transaction in flight
    // transaction outlives disable
    always_ff @(posedge sys_clk or posedge sys_rst) begin
        if (sys_rst)
            xact_cnt <= 8'h00;
        else if (start_xact)
            xact_cnt <= xact_len;
        else if (xact_cnt != 8'h00)
            xact_cnt <= xact_cnt - 8'h01;
    end
    assign xact_active = (xact_cnt != 8'h00);
    //==========================================================================
    // Pending frames; a slow abort keeps them pending for abort_lat+1 cycles
    // buffers obey abort
    always_ff @(posedge sys_clk or posedge sys_rst) begin
        if (sys_rst) begin
            tx_pending <= 1'b0;
            abort_cnt  <= 4'h0;
        end else if (load_tx) begin
            tx_pending <= 1'b1;
        end else if (tx_abort_req && tx_pending) begin
            abort_cnt  <= abort_cnt + 4'h1;
            tx_pending <= (abort_cnt < abort_lat);
        end else begin
            abort_cnt  <= 4'h0;
        end
    end
    //==========================================================================
    // Frames are only seen while the module runs
    always_ff @(posedge sys_clk or posedge sys_rst) begin
        if (sys_rst)
            rx_msg_valid <= 1'b0;
        else
            rx_msg_valid <= send_frame & can_run;
    end
endmodule // cmmc_can_node_model
`default_nettype wire

// ---- testbench.sv ----
// Self-checking testbench for the CAN module mode control block
`timescale 1ns/1ps
`default_nettype none
module testbench;
    typedef struct {logic [2:0] mode; logic [4:0] cnt; logic cap; logic [2:0] st;} cmmc_row_t;
    localparam logic [31:0] JUNK = 32'hF0EF_5FE0;
    logic        sys_clk, sys_rst, hsel, hwrite, sys_idle, start_xact, load_tx, send_frame, seen;
    logic [31:0] haddr, hwdata, hrdata, r, t1, t2;
    logic [1:0]  htrans;
    logic [2:0]  hsize, op_mode;
    logic        hready, hreadyout, hresp, xact_active, tx_pending, rx_msg_valid;
    logic        tx_abort_req, can_run, rx_stamp_valid;
    logic [17:0] filter_compare_mask;
    logic [15:0] rx_stamp;
    int          n_fail, checks_done;
    cmmc_row_t   rows[8];
    assign hready = hreadyout;
    cmmc_top uut (.sys_clk(sys_clk), .sys_rst(sys_rst), .hsel(hsel), .haddr(haddr), .htrans(htrans),
        .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hready), .hrdata(hrdata),
        .hreadyout(hreadyout), .hresp(hresp), .sys_idle(sys_idle), .xact_active(xact_active),
        .tx_pending(tx_pending), .rx_msg_valid(rx_msg_valid), .tx_abort_req(tx_abort_req),
        .can_run(can_run), .op_mode(op_mode), .filter_compare_mask(filter_compare_mask),
        .rx_stamp(rx_stamp), .rx_stamp_valid(rx_stamp_valid));
    cmmc_can_node_model node (.sys_clk(sys_clk), .sys_rst(sys_rst), .can_run(can_run),
        .tx_abort_req(tx_abort_req), .xact_len(8'h14), .start_xact(start_xact), .load_tx(load_tx),
        .abort_lat(4'hA), .send_frame(send_frame), .xact_active(xact_active), .tx_pending(tx_pending),
        .rx_msg_valid(rx_msg_valid));
    //==========================================================================
    // Bus tasks and checks
    task automatic ahb(input logic w, input logic [7:0] a, input logic [31:0] d, output logic [31:0] q);
        @(posedge sys_clk);
        htrans <= cmmc_pkg::HTRANS_NSEQ;
        haddr  <= {24'h0, a};
        hwrite <= w;
        hsel   <= 1'b1;
        do @(posedge sys_clk); while (hready !== 1'b1);
        htrans <= 2'h0;
        hsel   <= 1'b0;
        hwdata <= d;
        do @(posedge sys_clk); while (hready !== 1'b1);
        q = hrdata;
    endtask
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        checks_done++;
        if (got !== exp) begin
            n_fail++;
            $display("wrong value at %0t: got %h, expected %h", $time, got, exp);
        end
    endtask
    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        ahb(1'b1, a, d, r);
    endtask
    task automatic rdc(input logic [7:0] a, input logic [31:0] exp);
        ahb(1'b0, a, 32'h0, r);
        chk(r, exp);
    endtask
    task automatic pulse(input logic [2:0] s);
        {start_xact, load_tx, send_frame} <= s;
        @(posedge sys_clk);
        {start_xact, load_tx, send_frame} <= 3'b000;
    endtask
    task automatic end_of_test();
        if (n_fail == 0 && checks_done > 0)
            $display("== PASSED ==");
        else
            $display("== FAILED ==");
        $finish;
    endtask
    //==========================================================================
    // Clock, reset and watchdog
    initial begin
        sys_clk = 1'b0;
        forever #12.5 sys_clk = ~sys_clk;
    end
    initial begin
        repeat (3000) @(posedge sys_clk);
        n_fail++;
        end_of_test();
    end
    //==========================================================================
    // Main sequence
    initial begin
        {sys_rst, hsel, hwrite, sys_idle, start_xact, load_tx, send_frame} = 7'b1000000;
        {haddr, hwdata, htrans} = '0;
        hsize = cmmc_pkg::HSIZE_WORD;
        rows = '{'{0, 0, 1, 0}, '{1, 1, 0, 1}, '{2, 5, 1, 2}, '{3, 18, 0, 3},
                 '{4, 17, 0, 4}, '{7, 2, 1, 7}, '{5, 9, 0, 7}, '{6, 18, 1, 7}};
        repeat (2) @(posedge sys_clk);
        sys_rst <= 1'b0;
        rdc(8'h00, 32'h0480_0000);
        chk({29'h0, op_mode}, {29'h0, cmmc_pkg::MODE_RESET});
        rdc(8'h08, 32'h0);
        chk({31'h0, hresp}, 32'h0);
        foreach (rows[i]) begin
            wr(8'h00, JUNK | {5'h0, rows[i].mode, 3'h0, rows[i].cap, 15'h0, rows[i].cnt});
            repeat (3) @(posedge sys_clk);
            rdc(8'h00, {5'h0, rows[i].mode, rows[i].st, rows[i].cap, 15'h0, rows[i].cnt});
            chk({29'h0, op_mode}, {29'h0, rows[i].st});
            chk({14'h0, filter_compare_mask}, {13'h0, (19'h1 << rows[i].cnt) - 19'h1});
        end
        // Mode change and disable held off by a transaction in flight
        pulse(3'b100);
        wr(8'h00, 32'h0);
        rdc(8'h00, 32'h00E0_0000);
        repeat (20) @(posedge sys_clk);
        rdc(8'h00, 32'h0);
        wr(8'h00, 32'h0000_8000);
        rdc(8'h00, 32'h0000_8800);
        pulse(3'b100);
        wr(8'h00, 32'h0);
        rdc(8'h00, 32'h0000_0800);
        chk({31'h0, can_run}, 32'h1);
        repeat (20) @(posedge sys_clk);
        rdc(8'h00, 32'h0);
        chk({31'h0, can_run}, 32'h0);
        // Idle stop only with stop-in-idle set
        wr(8'h00, 32'h0000_A000);
        sys_idle <= 1'b1;
        repeat (3) @(posedge sys_clk);
        chk({31'h0, can_run}, 32'h0);
        wr(8'h00, 32'h0000_8000);
        repeat (3) @(posedge sys_clk);
        chk({31'h0, can_run}, 32'h1);
        sys_idle <= 1'b0;
        // Abort with a slow buffer, then self-clear
        pulse(3'b010);
        wr(8'h00, 32'h0800_8000);
        rdc(8'h00, 32'h0800_8800);
        chk({31'h0, tx_abort_req}, 32'h1);
        repeat (15) @(posedge sys_clk);
        rdc(8'h00, 32'h0000_8800);
        chk({31'h0, tx_abort_req | tx_pending}, 32'h0);
        // Time stamp capture on and off
        for (int c = 1; c >= 0; c--) begin
            wr(8'h00, {11'h0, c[0], 20'h0_8000});
            ahb(1'b0, 8'h04, 32'h0, t1);
            repeat (5) @(posedge sys_clk);
            ahb(1'b0, 8'h04, 32'h0, t2);
            chk({31'h0, t2[15:0] != t1[15:0]}, {31'h0, c[0]});
            pulse(3'b001);
            seen = 1'b0;
            repeat (4) @(posedge sys_clk) seen |= (rx_stamp_valid === 1'b1);
            chk({31'h0, seen}, {31'h0, c[0]});
            chk({31'h0, rx_stamp >= t2[15:0]}, {31'h0, c[0]});
        end
        end_of_test();
    end
endmodule // testbench
`default_nettype wire
